// ==== icc_pkg.sv ====
`default_nettype none
package icc_pkg;
   // ----------------------------------------------------------------
   // Register map, byte addresses on the register bus
   // ----------------------------------------------------------------
   localparam logic [7:0]  OFF_CTRL   = 8'h00;  // capture_control
   localparam logic [7:0]  OFF_BUF    = 8'h04;  // Capture buffer, read pops
   localparam logic [7:0]  OFF_STAT   = 8'h08;  // Interrupt status, write one to clear
   localparam logic [7:0]  OFF_MASK   = 8'h0C;  // Interrupt mask
   // ----------------------------------------------------------------
   // Field positions of capture_control
   // ----------------------------------------------------------------
   localparam int          B_SIDL     = 13;
   localparam int          B_TSEL     = 7;
   localparam int          B_CPI      = 5;
   localparam int          B_OVF      = 4;
   localparam int          B_BNE      = 3;
   localparam int          B_MODE     = 0;
   localparam logic [15:0] CTRL_RST   = 16'h0000;
   // ----------------------------------------------------------------
   // Status bits, capture buffer, prescaler and bus answers
   // ----------------------------------------------------------------
   localparam int          ST_CAP     = 0;
   localparam int          ST_OVF     = 1;
   localparam int          ST_WAKE    = 2;
   localparam int          ST_W       = 3;
   localparam int          CAP_W      = 16;
   localparam int          FIFO_DEPTH = 4;
   localparam logic [3:0]  PRE4_LAST  = 4'h3;
   localparam logic [3:0]  PRE16_LAST = 4'hF;
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;

   typedef enum logic [2:0] {
      MODE_OFF    = 3'h0,
      MODE_BOTH   = 3'h1,
      MODE_FALL   = 3'h2,
      MODE_RISE   = 3'h3,
      MODE_PRE4   = 3'h4,
      MODE_PRE16  = 3'h5,
      MODE_UNUSED = 3'h6,
      MODE_WAKE   = 3'h7
   } icc_mode_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } icc_wr_t;
endpackage : icc_pkg
`default_nettype wire

// ==== icc_edge.sv ====
`timescale 1ns/1ps
`default_nettype none
module icc_edge (
   input  wire logic clock_in,
   input  wire logic srst_in,
   input  wire logic pin_in,
   output logic      rise_out,
   output logic      fall_out
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic prev;
      logic primed;
   } icc_edge_st_t;

   icc_edge_st_t q, d;

   // The primed bit keeps a pin that is already high at reset from
   // looking like a rising edge in the first cycle.
   always_comb begin
      d        = q;
      d.prev   = pin_in;
      d.primed = 1'b1;
      rise_out = q.primed & pin_in & ~q.prev;
      fall_out = q.primed & ~pin_in & q.prev;
   end

   // Register the state.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule : icc_edge
`default_nettype wire

// ==== icc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module icc_fifo import icc_pkg::*; #(
   parameter int WIDTH = CAP_W,
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic             clock_in,
   input  wire logic             srst_in,
   input  wire logic             push_in,
   input  wire logic [WIDTH-1:0] push_data_in,
   input  wire logic             pop_in,
   output logic      [WIDTH-1:0] head_out,
   output logic                  empty_out,
   output logic                  full_out
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = PW + 1;

   // ----------------------------------------------------------------
   // State; pointers wrap naturally, so DEPTH must be a power of two
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               rp;
      logic [PW-1:0]               wp;
      logic [CW-1:0]               cnt;
   } icc_fifo_st_t;

   icc_fifo_st_t q, d;
   logic         push_ok;
   logic         pop_ok;

   // A push into a full buffer is dropped; the caller flags overflow.
   always_comb begin
      d         = q;
      empty_out = (q.cnt == '0);
      full_out  = (q.cnt == CW'(DEPTH));
      head_out  = q.mem[q.rp];
      push_ok   = push_in & ~full_out;
      pop_ok    = pop_in & ~empty_out;
      if (push_ok) begin
         d.mem[q.wp] = push_data_in;
         d.wp        = PW'(q.wp + 1'b1);
      end
      if (pop_ok) begin
         d.rp = PW'(q.rp + 1'b1);
      end
      d.cnt = CW'(q.cnt + CW'(push_ok) - CW'(pop_ok));
   end

   // Register the state.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   AST_FIFO_COUNT: assert property (@(posedge clock_in) disable iff (srst_in)
      push_ok && !pop_ok |=> q.cnt == $past(q.cnt) + 1'b1)
      else $error("Buffer count did not rise on push.");
   AST_FIFO_FULL_HOLD: assert property (@(posedge clock_in) disable iff (srst_in)
      push_in && full_out && !pop_in |=> $stable(q.mem) && full_out)
      else $error("Full buffer changed on dropped push.");
endmodule : icc_fifo
`default_nettype wire

// ==== icc_capture_channel.sv ====
// Functional notes
// - A qualifying pin event stores the 16-bit count of the chosen time base.
// - Time-base select one takes the first timer, zero takes the second.
// - Captured values wait in a four-entry first-in first-out buffer.
// - The two-bit captures-per-interrupt field raises the interrupt every 1st to 4th capture.
// - The overflow flag is read-only, set by an overflow and cleared only by hardware.
// - The not-empty flag is read-only and shows that the buffer holds a value.
// - Mode 000 turns the channel off with no captures.
// - Mode 001 captures on both edges and interrupts on every capture.
// - Mode 010 captures falling edges and mode 011 rising edges.
// - Mode 100 captures every 4th and mode 101 every 16th rising edge.
// - Mode 110 is unused and behaves as off.
// - Mode 111 only raises an interrupt on rising edges in Sleep or Idle.
// - With stop-in-idle set the channel stops capturing while the CPU is idle; the mode 111 wake still works.
// - A pin event can wake the device from Sleep and Idle.
// - Unimplemented control bits read zero and ignore writes.
`timescale 1ns/1ps
`default_nettype none
module icc_capture_channel import icc_pkg::*; #(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock_in,
   input  wire logic              srst_in,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr_in,
   input  wire logic              s_axi_awvalid_in,
   output logic                   s_axi_awready_out,
   input  wire logic [31:0]       s_axi_wdata_in,
   input  wire logic [3:0]        s_axi_wstrb_in,
   input  wire logic              s_axi_wvalid_in,
   output logic                   s_axi_wready_out,
   output logic      [1:0]        s_axi_bresp_out,
   output logic                   s_axi_bvalid_out,
   input  wire logic              s_axi_bready_in,
   input  wire logic [ADDR_W-1:0] s_axi_araddr_in,
   input  wire logic              s_axi_arvalid_in,
   output logic                   s_axi_arready_out,
   output logic      [31:0]       s_axi_rdata_out,
   output logic      [1:0]        s_axi_rresp_out,
   output logic                   s_axi_rvalid_out,
   input  wire logic              s_axi_rready_in,
   input  wire logic              capture_input_pin_in,
   input  wire logic [CAP_W-1:0]  time_base_first_in,
   input  wire logic [CAP_W-1:0]  time_base_second_in,
   input  wire logic              cpu_idle_in,
   input  wire logic              cpu_sleep_in,
   output logic                   irq_out,
   output logic                   wake_out
);
   // ----------------------------------------------------------------
   // State of the whole channel
   // ----------------------------------------------------------------
   typedef struct packed {
      icc_wr_t           wr;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] waddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
      logic              stop_idle;
      logic              tsel;
      logic [1:0]        cpi;
      icc_mode_t         mode;
      logic              ovf;
      logic [3:0]        pre;
      logic [1:0]        icnt;
      logic [ST_W-1:0]   sts;
      logic [ST_W-1:0]   msk;
      logic              wake;
   } icc_st_t;

   icc_st_t           q, d;
   logic              rise, fall, empty, full, push, pop;
   logic [CAP_W-1:0]  head, tb;
   logic              aw_take, w_take, ar_take, wr_fire, run, ev, lowpow;
   logic              cap_int, ovf_set, wake_ev, ctrl_wr;
   logic [ADDR_W-1:0] wa, ra;
   logic [31:0]       wdat;
   logic [3:0]        wstb;
   logic [ST_W-1:0]   sts_clr;
   logic [15:0]       ctrl_rd;

   // ----------------------------------------------------------------
   // Edge detection and capture buffer
   // ----------------------------------------------------------------
   icc_edge u_edge (
      .clock_in (clock_in),
      .srst_in  (srst_in),
      .pin_in   (capture_input_pin_in),
      .rise_out (rise),
      .fall_out (fall)
   );

   icc_fifo #(
      .WIDTH (CAP_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clock_in     (clock_in),
      .srst_in      (srst_in),
      .push_in      (push),
      .push_data_in (tb),
      .pop_in       (pop),
      .head_out     (head),
      .empty_out    (empty),
      .full_out     (full)
   );

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   // Captures are evaluated before register writes so that a control
   // write in the same cycle still restarts the event counters cleanly.
   always_comb begin
      d       = q;
      sts_clr = '0;
      ctrl_wr = 1'b0;
      cap_int = 1'b0;
      ev      = 1'b0;
      lowpow  = cpu_idle_in | cpu_sleep_in;
      run     = ~(cpu_idle_in & q.stop_idle);
      tb      = q.tsel ? time_base_first_in : time_base_second_in;

      // Qualify the pin edges by mode.
      case (q.mode)
         MODE_BOTH:  ev = rise | fall;
         MODE_FALL:  ev = fall;
         MODE_RISE:  ev = rise;
         MODE_PRE4:  ev = rise & (q.pre == PRE4_LAST);
         MODE_PRE16: ev = rise & (q.pre == PRE16_LAST);
         default:    ev = 1'b0;
      endcase
      ev = ev & run;

      // The prescaler counts rising edges only in the prescaled modes.
      if (run && rise && (q.mode == MODE_PRE4 || q.mode == MODE_PRE16)) begin
         d.pre = ev ? 4'h0 : 4'(q.pre + 4'h1);
      end

      // Interrupt after the selected number of captures.
      if (ev) begin
         if (q.mode == MODE_BOTH || q.icnt == q.cpi) begin
            cap_int = 1'b1;
            d.icnt  = 2'h0;
         end else begin
            d.icnt = 2'(q.icnt + 2'h1);
         end
      end

      push    = ev & ~full;
      ovf_set = ev & full;
      wake_ev = (q.mode == MODE_WAKE) & rise & lowpow;
      d.wake  = (ev & lowpow) | wake_ev;

      // Write address and data are taken in either order.
      s_axi_awready_out = (q.wr == WR_IDLE) & ~q.aw_got;
      s_axi_wready_out  = (q.wr == WR_IDLE) & ~q.w_got;
      s_axi_bvalid_out  = (q.wr == WR_RESP);
      aw_take = s_axi_awvalid_in & s_axi_awready_out;
      w_take  = s_axi_wvalid_in & s_axi_wready_out;
      wa      = q.aw_got ? q.waddr : s_axi_awaddr_in;
      wdat    = q.w_got ? q.wdata : s_axi_wdata_in;
      wstb    = q.w_got ? q.wstrb : s_axi_wstrb_in;
      wr_fire = 1'b0;
      case (q.wr)
         WR_IDLE: begin
            if (aw_take) begin
               d.aw_got = 1'b1;
               d.waddr  = s_axi_awaddr_in;
            end
            if (w_take) begin
               d.w_got = 1'b1;
               d.wdata = s_axi_wdata_in;
               d.wstrb = s_axi_wstrb_in;
            end
            wr_fire = (q.aw_got | aw_take) & (q.w_got | w_take);
         end
         WR_RESP: begin
            if (s_axi_bready_in) begin
               d.wr = WR_IDLE;
            end
         end
         default: d.wr = WR_IDLE;
      endcase

      // Register writes; only implemented control bits are stored.
      if (wr_fire) begin
         d.wr     = WR_RESP;
         d.aw_got = 1'b0;
         d.w_got  = 1'b0;
         d.bresp  = RESP_OKAY;
         if (wa == ADDR_W'(OFF_CTRL)) begin
            ctrl_wr = 1'b1;
            if (wstb[0]) begin
               d.tsel = wdat[B_TSEL];
               d.cpi  = wdat[B_CPI +: 2];
               d.mode = icc_mode_t'(wdat[B_MODE +: 3]);
            end
            if (wstb[1]) begin
               d.stop_idle = wdat[B_SIDL];
            end
         end else if (wa == ADDR_W'(OFF_STAT)) begin
            sts_clr = wstb[0] ? wdat[ST_W-1:0] : '0;
         end else if (wa == ADDR_W'(OFF_MASK)) begin
            if (wstb[0]) begin
               d.msk = wdat[ST_W-1:0];
            end
         end else if (wa != ADDR_W'(OFF_BUF)) begin
            d.bresp = RESP_SLV;
         end
      end
      if (ctrl_wr) begin
         d.pre  = 4'h0;
         d.icnt = 2'h0;
      end

      // Reads; a buffer read pops the oldest entry.
      ctrl_rd = {2'b00, q.stop_idle, 5'b00000, q.tsel, q.cpi, q.ovf, ~empty,
                 q.mode};
      s_axi_arready_out = ~q.rvalid;
      ar_take = s_axi_arvalid_in & s_axi_arready_out;
      ra      = s_axi_araddr_in;
      pop     = ar_take & (ra == ADDR_W'(OFF_BUF)) & ~empty;
      if (ar_take) begin
         d.rvalid = 1'b1;
         d.rresp  = RESP_OKAY;
         if (ra == ADDR_W'(OFF_CTRL)) begin
            d.rdata = {16'h0000, ctrl_rd};
         end else if (ra == ADDR_W'(OFF_BUF)) begin
            d.rdata = empty ? 32'h0000_0000 : {16'h0000, head};
         end else if (ra == ADDR_W'(OFF_STAT)) begin
            d.rdata = {29'h0000_0000, q.sts};
         end else if (ra == ADDR_W'(OFF_MASK)) begin
            d.rdata = {29'h0000_0000, q.msk};
         end else begin
            d.rdata = 32'h0000_0000;
            d.rresp = RESP_SLV;
         end
      end else if (q.rvalid && s_axi_rready_in) begin
         d.rvalid = 1'b0;
      end

      // Overflow clears on a buffer read; a new overflow wins.
      d.ovf = (q.ovf & ~pop) | ovf_set;
      d.sts = (q.sts & ~sts_clr) | {wake_ev, ovf_set, cap_int};
   end

   // Register the state.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         q           <= '0;
         q.wr        <= WR_IDLE;
         q.mode      <= icc_mode_t'(CTRL_RST[B_MODE +: 3]);
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   // Bus data and the wake pulse come straight from flip-flops.
   assign s_axi_bresp_out  = q.bresp;
   assign s_axi_rvalid_out = q.rvalid;
   assign s_axi_rdata_out  = q.rdata;
   assign s_axi_rresp_out  = q.rresp;
   assign irq_out          = |(q.sts & q.msk);
   assign wake_out         = q.wake;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (srst_in);

   AST_TIMEBASE_SEL: assert property (!q.tsel && push && empty
      |=> head == $past(time_base_second_in))
      else $error("Select zero did not store the second timer.");
   AST_FIRST_TIMER: assert property (q.tsel && push && empty
      |=> head == $past(time_base_first_in))
      else $error("Select one did not store the first timer.");
   AST_OFF_NO_CAPTURE: assert property ((q.mode == MODE_OFF || q.mode == MODE_UNUSED
      || q.mode == MODE_WAKE) |-> !push && !ovf_set)
      else $error("Capture happened in an off mode.");
   AST_FALL_CAPTURE: assert property (q.mode == MODE_FALL && fall && run && !full
      |-> push ##1 !empty)
      else $error("Falling edge was not captured.");
   AST_BOTH_IRQ: assert property (q.mode == MODE_BOTH && (rise || fall) && run
      |=> q.sts[ST_CAP])
      else $error("Edge capture did not flag an interrupt.");
   AST_PRE16_SKIP: assert property (q.mode == MODE_PRE16 && rise && q.pre != PRE16_LAST
      |-> !push)
      else $error("Prescaled mode captured early.");
   AST_CPI_WAIT: assert property (ev && q.mode != MODE_BOTH && q.icnt != q.cpi
      |=> q.icnt == $past(q.icnt) + 2'h1)
      else $error("Capture count per interrupt did not advance.");
   AST_IDLE_HALT: assert property (cpu_idle_in && q.stop_idle |-> !push
      && !cap_int)
      else $error("Channel captured while halted in idle.");
   AST_WAKE_PULSE: assert property (q.mode == MODE_WAKE && rise && cpu_sleep_in
      |=> wake_out && q.sts[ST_WAKE])
      else $error("Wake edge did not raise wake and status.");
   AST_OVF_SET: assert property (ev && full |=> q.ovf && q.sts[ST_OVF])
      else $error("Overflow not flagged on full buffer.");
   AST_CTRL_ZERO: assert property (ar_take && ra == ADDR_W'(OFF_CTRL)
      |=> s_axi_rdata_out[12:8] == 5'h00 && s_axi_rdata_out[31:14] == '0
      && s_axi_rdata_out[B_BNE] == $past(!empty))
      else $error("Control readback wrong.");
   AST_POP_HEAD: assert property (pop |=> s_axi_rdata_out[15:0] == $past(head))
      else $error("Buffer read did not return the oldest value.");

   // The checks below tie the rising and prescale-by-4 modes to their edges and guard the flags that
   // only hardware may set; a wrong decode or a lost set trips one of them.
   AST_RISE_CAPTURE: assert property (q.mode == MODE_RISE && rise && run && !full
      |-> push)
      else $error("Rising edge was not captured.");
   AST_RISE_ONLY: assert property (q.mode == MODE_RISE && fall |-> !push)
      else $error("Falling edge captured in rising mode.");
   AST_PRE4_CAPTURE: assert property (q.mode == MODE_PRE4 && rise && run && !full
      && q.pre == PRE4_LAST |-> push)
      else $error("Fourth rising edge was not captured.");
   AST_OVF_HW_ONLY: assert property (!q.ovf && !ovf_set |=> !q.ovf)
      else $error("Overflow flag set without an overflow.");
   AST_BNE_AFTER_PUSH: assert property (push |=> !empty)
      else $error("Buffer empty after a capture.");
   AST_STS_CAP: assert property (cap_int |=> q.sts[ST_CAP])
      else $error("Capture interrupt lost to a clear.");
   AST_WAKE_CAPTURE: assert property (ev && lowpow |=> wake_out)
      else $error("Capture in low power did not wake.");
   AST_IDLE_PRE_HOLD: assert property (cpu_idle_in && q.stop_idle && !ctrl_wr
      |=> q.pre == $past(q.pre))
      else $error("Prescaler moved while halted in idle.");

   COV_OVERFLOW: cover property (ev && full);
   COV_PRE16: cover property (q.mode == MODE_PRE16 && push);
   COV_WAKE: cover property (wake_ev ##1 irq_out);
   COV_BOTH_IRQ: cover property (q.mode == MODE_BOTH && cap_int);
   COV_IDLE_HALT: cover property (cpu_idle_in && q.stop_idle && rise);
endmodule : icc_capture_channel
`default_nettype wire

// ==== icc_pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Far-side source of the capture pin and of the two timer counts
// ----------------------------------------------------------------
module icc_pin_model import icc_pkg::*; (
   input  wire logic             clock_in,
   input  wire logic             srst_in,
   input  wire logic             level_in,
   input  wire logic [CAP_W-1:0] count_in,
   output logic                  pin_out,
   output logic      [CAP_W-1:0] first_out,
   output logic      [CAP_W-1:0] second_out
);
   // Pin and counts move only on a clock edge, as a synchronised pin would.
   // The second timer shows the inverse count, so a wrong select never matches by luck.
   always_ff @(posedge clock_in) begin
      if (srst_in) begin
         pin_out    <= 1'h0;
         first_out  <= 16'h0000;
         second_out <= 16'hFFFF;
      end else begin
         pin_out    <= level_in;
         first_out  <= count_in;
         second_out <= ~count_in;
      end
   end
endmodule : icc_pin_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import icc_pkg::*;;
   // ----------------------------------------------------------------
   // Signals, design and far side
   // ----------------------------------------------------------------
   logic        clk, rst, awv, wv, bry, arv, rry, lvl, idle, slp;
   logic        awr, wrdy, bv, arr, rv, irq, wake, pin;
   logic [7:0]  awa, ara;
   logic [31:0] wd, rdat, d;
   logic [15:0] cnt, tf, ts;
   logic [1:0]  br, rr, r;
   int          fail_count, checks_done, n, k;
   int          wake_n = 0;

   icc_capture_channel DUT (.clock_in(clk), .srst_in(rst),
      .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
      .s_axi_wready_out(wrdy), .s_axi_bresp_out(br), .s_axi_bvalid_out(bv),
      .s_axi_bready_in(bry), .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv),
      .s_axi_arready_out(arr), .s_axi_rdata_out(rdat), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rry), .capture_input_pin_in(pin),
      .time_base_first_in(tf), .time_base_second_in(ts), .cpu_idle_in(idle),
      .cpu_sleep_in(slp), .irq_out(irq), .wake_out(wake));
   icc_pin_model FAR (.clock_in(clk), .srst_in(rst), .level_in(lvl), .count_in(cnt),
      .pin_out(pin), .first_out(tf), .second_out(ts));

   // Wake pulses last one cycle, so they are counted rather than polled.
   always @(posedge clk) begin
      if (wake === 1'h1) wake_n <= wake_n + 1;
   end

   initial begin
      clk = 1'h0;
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Bus cycles, comparison and pin stimulus
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask : chk

   // Address and data are offered together and each is dropped once taken.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      int i;
      @(posedge clk);
      awa <= a;
      wd  <= v;
      awv <= 1'h1;
      wv  <= 1'h1;
      bry <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (awv && awr) awv <= 1'h0;
         if (wv && wrdy) wv <= 1'h0;
         if (bv) break;
      end
      bry <= 1'h0;
      if (i == 50) chk(32'h0, 32'h1, "write answer missing");
   endtask : wr

   task automatic rd(input logic [7:0] a);
      int i;
      @(posedge clk);
      ara <= a;
      arv <= 1'h1;
      rry <= 1'h1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (arv && arr) arv <= 1'h0;
         if (rv) break;
      end
      d = rdat;
      r = rr;
      rry <= 1'h0;
      if (i == 50) chk(32'h0, 32'h1, "read answer missing");
   endtask : rd

   // Counts are held steady around both edges so either edge captures v.
   task automatic pulse(input logic [15:0] v);
      @(posedge clk);
      cnt <= v;
      lvl <= 1'h1;
      repeat (3) @(posedge clk);
      lvl <= 1'h0;
      repeat (3) @(posedge clk);
   endtask : pulse

   // Pops the buffer until it reports empty and returns how many were held.
   task automatic drain();
      n = 0;
      repeat (6) begin
         rd(OFF_CTRL);
         if (d[B_BNE] !== 1'h1) break;
         rd(OFF_BUF);
         n++;
      end
   endtask : drain

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_regs();
      rd(OFF_CTRL);
      chk(d, 32'h0, "control after reset");
      wr(OFF_CTRL, 32'hFFFF_FFFF);
      rd(OFF_CTRL);
      chk(d, 32'h20E7, "control all ones");
      rd(8'h10);
      chk({30'h0, r}, {30'h0, RESP_SLV}, "unmapped read");
      wr(8'h10, 32'h1);
      chk({30'h0, br}, {30'h0, RESP_SLV}, "unmapped write");
      rd(OFF_MASK);
      chk(d, 32'h0, "mask after reset");
   endtask : t_regs

   task automatic t_select();
      wr(OFF_CTRL, 32'h83);
      pulse(16'h1234);
      rd(OFF_CTRL);
      chk(d, 32'h8B, "not-empty after capture");
      rd(OFF_BUF);
      chk(d, 32'h1234, "first timer captured");
      wr(OFF_CTRL, 32'h03);
      pulse(16'h1234);
      rd(OFF_BUF);
      chk(d, 32'hEDCB, "second timer captured");
      rd(OFF_CTRL);
      chk(d, 32'h03, "empty after last pop");
   endtask : t_select

   task automatic t_fifo();
      wr(OFF_CTRL, 32'h83);
      for (int i = 0; i < 5; i++) pulse(16'h0100 + 16'(i));
      rd(OFF_CTRL);
      chk(d, 32'h9B, "overflow on fifth capture");
      for (int i = 0; i < 4; i++) begin
         rd(OFF_BUF);
         chk(d, 32'h0100 + i, "oldest value first");
      end
      rd(OFF_CTRL);
      chk(d, 32'h83, "flags cleared by hardware");
   endtask : t_fifo

   // A control write restarts the prescaler, so each row starts clean.
   task automatic t_modes();
      int np [8] = '{2, 2, 2, 2, 8, 16, 2, 2};
      int ne [8] = '{0, 4, 2, 2, 2, 1, 0, 0};
      for (int m = 0; m < 8; m++) begin
         wr(OFF_CTRL, 32'(m));
         for (int p = 0; p < np[m]; p++) pulse(16'(m));
         drain();
         chk(32'(n), 32'(ne[m]), "captures for mode");
      end
   endtask : t_modes

   task automatic t_irq();
      wr(OFF_MASK, 32'h1);
      for (int c = 0; c < 4; c++) begin
         wr(OFF_CTRL, 32'h3 | (c << 5));
         wr(OFF_STAT, 32'h7);
         for (int p = 0; p < c; p++) pulse(16'h0);
         chk({31'h0, irq}, 32'h0, "irq before count");
         pulse(16'h0);
         chk({31'h0, irq}, 32'h1, "irq at count");
         drain();
      end
      wr(OFF_STAT, 32'h1);
      chk({31'h0, irq}, 32'h0, "irq after clear");
      wr(OFF_CTRL, 32'h61);
      pulse(16'h0);
      chk({31'h0, irq}, 32'h1, "both-edge mode ignores count");
      drain();
      wr(OFF_MASK, 32'h0);
      chk({31'h0, irq}, 32'h0, "irq masked");
   endtask : t_irq

   task automatic t_power();
      @(posedge clk);
      idle <= 1'h1;
      wr(OFF_CTRL, 32'h2003);
      pulse(16'h0);
      drain();
      chk(32'(n), 32'h0, "halted in idle");
      wr(OFF_CTRL, 32'h3);
      k = wake_n;
      pulse(16'h0);
      drain();
      chk(32'(n), 32'h1, "runs in idle");
      chk(32'(wake_n - k), 32'h1, "wake from idle");
      @(posedge clk);
      idle <= 1'h0;
      slp  <= 1'h1;
      wr(OFF_CTRL, 32'h7);
      wr(OFF_STAT, 32'h7);
      k = wake_n;
      pulse(16'h0);
      rd(OFF_STAT);
      chk(d & 32'h4, 32'h4, "wake edge status");
      chk(32'(wake_n - k), 32'h1, "wake from sleep");
      drain();
      chk(32'(n), 32'h0, "no capture in wake mode");
      @(posedge clk);
      slp <= 1'h0;
   endtask : t_power

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : results

   // The whole run takes well under two thousand cycles; the watchdog allows far more.
   initial begin
      #100000;
      fail_count++;
      results();
   end

   initial begin
      fail_count  = 0;
      checks_done = 0;
      {awv, wv, bry, arv, rry, lvl, idle, slp} = 8'h00;
      {awa, ara, wd, cnt} = 64'h0;
      rst = 1'h1;
      repeat (10) @(posedge clk);
      rst <= 1'h0;
      t_regs();
      t_select();
      t_fifo();
      t_modes();
      t_irq();
      t_power();
      results();
   end
endmodule : tb_top
`default_nettype wire
